// file: verilog/vsf_top.sv
// valve state fieldbus slave core
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "vsf_defines.svh"
// Operation
// - valve state from four sensors per type
// - seat-lift type pattern table
// - bits 0..2 drive pilots, bit 3 ignored
// - sensor type passes raw bits
// - slave with polled, strobed, cos i/o
// - process and management messages kept apart
// - bit rate from two switches, default 125
// - node address 0..63, default 63
// - switch 1 is address lsb
// - one input and one output assembly
// - input assembly shows state or sensors
// - full power 200 ms, then holding
// - bus loss gives programmable safe state
module vsf_top #(
  parameter int PULL_CYC = `VSF_PULL_MS * `VSF_CLK_KHZ,
  parameter int WDOG_CYC = `VSF_WDOG_MS * `VSF_CLK_KHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ext_sensor_target_a,
  input  wire logic       ext_sensor_target_b,
  input  wire logic       int_sensor_target_a,
  input  wire logic       int_sensor_target_b,
  input  wire logic [5:0] addr_sw,
  input  wire logic [1:0] baud_sw,
  input  wire logic       msg_valid,
  input  wire logic       msg_is_io,
  input  wire logic [1:0] msg_kind,
  input  wire logic       pilot_out_bit0,
  input  wire logic       pilot_out_bit1,
  input  wire logic       pilot_out_bit2,
  input  wire logic       pilot_out_bit3,
  input  wire logic       can_bus_off,
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  output logic            tx_req,
  output logic            state_in_bit0,
  output logic            state_in_bit1,
  output logic            state_in_bit2,
  output logic            state_in_bit3,
  output logic            main_stroke_pilot,
  output logic            upper_lift_pilot,
  output logic            lower_lift_pilot,
  output logic [2:0]      pilot_boost,
  output logic            bus_lost,
  output logic [5:0]      node_address,
  output logic [1:0]      baud_sel
);
  localparam int WW = $clog2(WDOG_CYC + 1);
  localparam logic [WW-1:0] WD_MAX = WW'(WDOG_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  vsf_pkg::vsf_vtype_e vtype_reg;    // configured valve type
  logic [2:0]          safe_reg;     // safe pilot pattern
  logic                cos_en_reg;   // change-of-state connection open
  logic                cfg_done_reg; // switches already sampled
  logic [2:0]          cmd_reg;      // pilot bits from the master
  logic [WW-1:0]       wd_cnt_reg;   // cycles since last i/o message
  logic [15:0]         io_cnt_reg;   // process messages seen
  logic [15:0]         exp_cnt_reg;  // management messages seen
  logic [3:0]          tx_data_reg;  // last input assembly sent
  logic [3:0]          state_bits;   // decoded input assembly
  logic [3:0]          sens;         // taught sensor targets
  logic                io_msg;       // process message this cycle
  logic                exp_msg;      // management message this cycle
  logic                out_msg;      // process message with data
  logic                tx_fire;      // send input assembly
  logic [31:0]         rd_next;      // read data next value
  vsf_pilot_if         pif ();

  assign sens    = {int_sensor_target_b, int_sensor_target_a,
                    ext_sensor_target_b, ext_sensor_target_a};
  assign io_msg  = msg_valid && msg_is_io;
  assign exp_msg = msg_valid && !msg_is_io;
  // bit-strobe requests carry no pilot data for this node
  assign out_msg = io_msg && (msg_kind == 2'(vsf_pkg::MK_POLL) ||
                              msg_kind == 2'(vsf_pkg::MK_COS));

  ////////////////////////////////////////////////////////////////////////////
  // switch sampling
  // caught on the first clocked cycle after release, then frozen
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cfg_done_reg <= 1'b0;
      node_address <= `VSF_RST_ADDR;
      baud_sel     <= vsf_pkg::BR_125;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      node_address <= addr_sw;
      unique case (baud_sw)
        2'h1:    baud_sel <= vsf_pkg::BR_250;
        2'h2:    baud_sel <= vsf_pkg::BR_500;
        default: baud_sel <= vsf_pkg::BR_125;
      endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // control register writes
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      vtype_reg  <= vsf_pkg::vsf_vtype_e'(`VSF_RST_VTYPE);
      safe_reg   <= `VSF_RST_SAFE;
      cos_en_reg <= 1'b0;
    end
    else if (reg_wr && reg_addr == `VSF_OFS_CTRL)
    begin
      vtype_reg  <= vsf_pkg::vsf_vtype_e'(
                    reg_wdata[`VSF_CTRL_VT_LSB +: 2]);
      safe_reg   <= reg_wdata[`VSF_CTRL_SAFE_LSB +: 3];
      cos_en_reg <= reg_wdata[`VSF_CTRL_COS_BIT];
    end

  ////////////////////////////////////////////////////////////////////////////
  // output assembly
  // only process messages move the pilots; bit 3 is dropped
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      cmd_reg <= 3'h0;
    else if (out_msg)
      cmd_reg <= {pilot_out_bit2, pilot_out_bit1, pilot_out_bit0};

  ////////////////////////////////////////////////////////////////////////////
  // bus watchdog
  // saturates so a long silence cannot wrap back to healthy
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      wd_cnt_reg <= '0;
    else if (io_msg)
      wd_cnt_reg <= '0;
    else if (wd_cnt_reg != WD_MAX)
      wd_cnt_reg <= wd_cnt_reg + WW'(1);

  // starts lost so pilots sit safe until the master talks; set wins
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      bus_lost <= 1'b1;
    else if (can_bus_off || wd_cnt_reg == WD_MAX)
      bus_lost <= 1'b1;
    else if (io_msg)
      bus_lost <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // message statistics
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      io_cnt_reg  <= 16'h0;
      exp_cnt_reg <= 16'h0;
    end
    else
    begin
      if (io_msg)
        io_cnt_reg <= io_cnt_reg + 16'h1;
      if (exp_msg)
        exp_cnt_reg <= exp_cnt_reg + 16'h1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // input assembly
  vsf_decode u_decode (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sens       (sens),
    .vtype      (vtype_reg),
    .state_bits (state_bits)
  );

  // answer polls and strobes; with cos open, also each change
  assign tx_fire = (io_msg && (msg_kind == 2'(vsf_pkg::MK_POLL) ||
                               msg_kind == 2'(vsf_pkg::MK_STROBE))) ||
                   (cos_en_reg && state_bits != tx_data_reg);

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      tx_req      <= 1'b0;
      tx_data_reg <= 4'h0;
    end
    else
    begin
      tx_req <= tx_fire;
      if (tx_fire)
        tx_data_reg <= state_bits;
    end

  assign state_in_bit0 = tx_data_reg[0];
  assign state_in_bit1 = tx_data_reg[1];
  assign state_in_bit2 = tx_data_reg[2];
  assign state_in_bit3 = tx_data_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // pilot driver
  assign pif.cmd      = cmd_reg;
  assign pif.safe_val = safe_reg;
  assign pif.bus_lost = bus_lost;

  vsf_pilot_drv #(.PULL_CYC (PULL_CYC)) u_pilot (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pif     (pif.drv)
  );

  assign main_stroke_pilot = pif.on[0];
  assign upper_lift_pilot  = pif.on[1];
  assign lower_lift_pilot  = pif.on[2];
  assign pilot_boost       = pif.boost;

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  // unmapped offsets read zero; data appear one cycle after strobe
  always_comb
  begin
    rd_next = 32'h0;
    unique case (reg_addr)
      `VSF_OFS_CTRL:
      begin
        rd_next[`VSF_CTRL_VT_LSB +: 2]   = vtype_reg;
        rd_next[`VSF_CTRL_SAFE_LSB +: 3] = safe_reg;
        rd_next[`VSF_CTRL_COS_BIT]       = cos_en_reg;
      end
      `VSF_OFS_STATUS:
        rd_next[7:0] = {bus_lost, pif.on, state_bits};
      `VSF_OFS_CONFIG:
      begin
        rd_next[5:0] = node_address;
        rd_next[`VSF_CFG_BAUD_LSB +: 2] = baud_sel;
      end
      `VSF_OFS_MSGCNT:
        rd_next = {exp_cnt_reg, io_cnt_reg};
      default:
        rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_addr;
    $rose(cfg_done_reg) |-> node_address == $past(addr_sw);
  endproperty
  a_addr: assert property (p_addr)
    else $error("node address not sampled");

  property p_baud_dflt;
    $rose(cfg_done_reg) && $past(baud_sw) == `VSF_BAUD_SW_DFLT
      |-> baud_sel == vsf_pkg::BR_125;
  endproperty
  a_baud_dflt: assert property (p_baud_dflt)
    else $error("default bit rate wrong");

  property p_cfg_hold;
    cfg_done_reg |=> $stable(node_address) && $stable(baud_sel);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed after sampling");

  property p_poll_answer;
    io_msg && msg_kind == 2'(vsf_pkg::MK_POLL) |=> tx_req;
  endproperty
  a_poll_answer: assert property (p_poll_answer)
    else $error("poll not answered");

  property p_cmd_take;
    out_msg |=> cmd_reg == $past({pilot_out_bit2, pilot_out_bit1,
                                  pilot_out_bit0});
  endproperty
  a_cmd_take: assert property (p_cmd_take)
    else $error("pilot bits not taken");

  property p_exp_quiet;
    exp_msg |=> $stable(cmd_reg);
  endproperty
  a_exp_quiet: assert property (p_exp_quiet)
    else $error("management message moved pilots");

  property p_pilot_follow;
    out_msg && !bus_lost && !can_bus_off ##1 !bus_lost
      |=> main_stroke_pilot == $past(pilot_out_bit0, 2);
  endproperty
  a_pilot_follow: assert property (p_pilot_follow)
    else $error("main stroke pilot wrong");

  property p_tx_data;
    tx_req |-> tx_data_reg == $past(state_bits);
  endproperty
  a_tx_data: assert property (p_tx_data)
    else $error("input assembly stale");

  c_bus_lost: cover property ($rose(bus_lost));
  c_cos: cover property (cos_en_reg && !io_msg ##1 tx_req);
  c_poll: cover property (io_msg ##1 tx_req ##1 !bus_lost);
endmodule // vsf_top

// file: verilog/vsf_defines.svh
// constants of the valve state fieldbus slave
`ifndef VSF_DEFINES_SVH
`define VSF_DEFINES_SVH
`define VSF_CLK_KHZ      10000
`define VSF_PULL_MS      200
`define VSF_WDOG_MS      1000
`define VSF_OFS_CTRL     8'h00
`define VSF_OFS_STATUS   8'h04
`define VSF_OFS_CONFIG   8'h08
`define VSF_OFS_MSGCNT   8'h0c
`define VSF_CTRL_VT_LSB  0
`define VSF_CTRL_SAFE_LSB 4
`define VSF_CTRL_COS_BIT 8
`define VSF_CFG_BAUD_LSB 8
`define VSF_RST_VTYPE    2'h2
`define VSF_RST_SAFE     3'h0
`define VSF_RST_ADDR     6'h3f
`define VSF_BAUD_SW_DFLT 2'h3
`define VSF_P_CLOSED_A   4'ha
`define VSF_P_OPEN       4'h1
`define VSF_P_CLOSED_B   4'h8
`define VSF_P_UPPER_B    4'h4
`define VSF_P_UPPER_C    4'h6
`endif

// file: verilog/vsf_pkg.sv
// types of the valve state fieldbus slave
package vsf_pkg;
  // configured valve type
  typedef enum logic [1:0] {
    VT_MAIN = 2'h0,
    VT_DUAL = 2'h1,
    VT_LIFT = 2'h2,
    VT_SENS = 2'h3
  } vsf_vtype_e;
  // bus bit rate selection
  typedef enum logic [1:0] {
    BR_125 = 2'h0,
    BR_250 = 2'h1,
    BR_500 = 2'h2
  } vsf_baud_e;
  // kind of an i/o message
  typedef enum logic [1:0] {
    MK_POLL   = 2'h0,
    MK_STROBE = 2'h1,
    MK_COS    = 2'h2
  } vsf_kind_e;
endpackage

// file: verilog/vsf_pilot_if.sv
// interface between slave core and pilot driver
`timescale 1ns/10ps
interface vsf_pilot_if;
  logic [2:0] cmd;      // wanted pilot states
  logic [2:0] safe_val; // states while bus is lost
  logic       bus_lost; // bus communication lost
  logic [2:0] on;       // pilot energised
  logic [2:0] boost;    // pilot at full switching power
  modport drv (input cmd, safe_val, bus_lost, output on, boost);
  modport ctl (output cmd, safe_val, bus_lost, input on, boost);
endinterface

// file: verilog/vsf_decode.sv
// sensor pattern to input assembly decoder
`timescale 1ns/10ps
`include "vsf_defines.svh"
module vsf_decode (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        sens,       // bit0 = ext a .. bit3 = int b
  input  vsf_pkg::vsf_vtype_e    vtype,
  output logic      [3:0]        state_bits
);
  logic [3:0] pat; // pattern read as ext a, ext b, int a, int b

  assign pat = {sens[0], sens[1], sens[2], sens[3]};

  // one-hot state bits, raw sensor bits for the sensor type; a pattern outside the table gives zero
  function automatic logic [3:0] dec(vsf_pkg::vsf_vtype_e t,
                                     logic [3:0] p, logic [3:0] raw);
    logic [3:0] r;
    r = 4'h0;
    unique case (t)
      vsf_pkg::VT_MAIN:
      begin
        if (p == `VSF_P_CLOSED_A) r = 4'h1;
        if (p == `VSF_P_OPEN)     r = 4'h2;
      end
      vsf_pkg::VT_DUAL:
      begin
        if (p == `VSF_P_CLOSED_B) r = 4'h1;
        if (p == `VSF_P_OPEN)     r = 4'h2;
        if (p == `VSF_P_UPPER_B)  r = 4'h4;
        if (p == `VSF_P_CLOSED_A) r = 4'h8;
      end
      vsf_pkg::VT_LIFT:
      begin
        if (p == `VSF_P_CLOSED_A) r = 4'h1;
        if (p == `VSF_P_OPEN)     r = 4'h2;
        if (p == `VSF_P_UPPER_C)  r = 4'h4;
        if (p == `VSF_P_CLOSED_B) r = 4'h8;
      end
      vsf_pkg::VT_SENS: r = raw;
    endcase
    return r;
  endfunction

  // registered so the assembly never shows a half-settled pattern
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      state_bits <= 4'h0;
    else
      state_bits <= dec(vtype, pat, sens);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_lift_closed;
    vtype == vsf_pkg::VT_LIFT && pat == `VSF_P_CLOSED_A |=> state_bits == 4'h1;
  endproperty
  a_lift_closed: assert property (p_lift_closed)
    else $error("closed pattern not decoded");

  property p_sens_pass;
    vtype == vsf_pkg::VT_SENS |=> state_bits == $past(sens);
  endproperty
  a_sens_pass: assert property (p_sens_pass)
    else $error("raw sensor bits not passed");

  property p_nomatch;
    vtype == vsf_pkg::VT_LIFT && pat != `VSF_P_CLOSED_A &&
    pat != `VSF_P_OPEN && pat != `VSF_P_UPPER_C &&
    pat != `VSF_P_CLOSED_B |=> state_bits == 4'h0;
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("unknown pattern reported a state");

  c_lower_lift: cover property (vtype == vsf_pkg::VT_LIFT ##1
                                state_bits == 4'h8);
endmodule // vsf_decode

// file: verilog/vsf_pilot_drv.sv
// pilot valve driver with pull-in boost and safe state
`timescale 1ns/10ps
module vsf_pilot_drv #(
  parameter int PULL_CYC = 2000000 // full power cycles after switch-on
) (
  input wire logic ref_clk,
  input wire logic rst,
  vsf_pilot_if.drv pif
);
  localparam int CW = $clog2(PULL_CYC + 1);
  localparam logic [CW-1:0] PULL = CW'(PULL_CYC);

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_pilot
      logic          want;  // wanted state after bus check
      logic [CW-1:0] cnt;   // boost cycles still to run
      logic [CW-1:0] hcnt;  // boost length seen, checking only

      // a lost bus hands the pilot to the programmable safe state
      assign want = pif.bus_lost ? pif.safe_val[i] : pif.cmd[i];

      // on follows want every cycle
      always_ff @(posedge ref_clk or posedge rst)
        if (rst)
          pif.on[i] <= 1'b0;
        else
          pif.on[i] <= want;

      // boost for exactly PULL cycles, then drop to holding level
      always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
          pif.boost[i] <= 1'b0;
          cnt          <= '0;
        end
        else if (!want)
        begin
          pif.boost[i] <= 1'b0;
          cnt          <= '0;
        end
        else if (!pif.on[i])
        begin
          pif.boost[i] <= 1'b1;
          cnt          <= PULL;
        end
        else if (cnt != '0)
        begin
          pif.boost[i] <= (cnt != CW'(1));
          cnt          <= cnt - CW'(1);
        end

      // counts boost cycles for the length check
      always_ff @(posedge ref_clk or posedge rst)
        if (rst)
          hcnt <= '0;
        else if (!pif.boost[i])
          hcnt <= '0;
        else
          hcnt <= hcnt + CW'(1);

      property p_boost_len;
        @(posedge ref_clk) disable iff (rst)
        $fell(pif.boost[i]) && pif.on[i] |-> hcnt == PULL;
      endproperty
      a_boost_len: assert property (p_boost_len)
        else $error("boost length wrong");

      property p_safe;
        @(posedge ref_clk) disable iff (rst)
        pif.bus_lost |=> pif.on[i] == $past(pif.safe_val[i]);
      endproperty
      a_safe: assert property (p_safe)
        else $error("pilot not in safe state");
    end
  endgenerate

  c_hold: cover property (@(posedge ref_clk) disable iff (rst)
                          $fell(pif.boost[0]) && pif.on[0]);
endmodule // vsf_pilot_drv

// file: dv/vsf_master_model.sv
// fieldbus master model: sends i/o and management messages, takes inputs
`timescale 1ns/10ps
module vsf_master_model (
  input  wire logic       ref_clk,
  output logic            msg_valid,
  output logic            msg_is_io,
  output logic [1:0]      msg_kind,
  output logic [3:0]      out_bits,
  input  wire logic       tx_req,
  input  wire logic [3:0] in_bits
);
  logic [1:0] seen_q; // tx_req history, assembly taken two edges later
  logic [3:0] rx_asm; // last input assembly received
  logic [3:0] rx_dec; // valve state decoded on the master side

  // quiet bus at time zero
  initial
  begin
    msg_valid = 1'b0;
    msg_is_io = 1'b0;
    msg_kind  = 2'h0;
    out_bits  = 4'h0;
    seen_q    = 2'h0;
    rx_asm    = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one message; lines are scrambled afterwards so no stale value helps
  task automatic send(input logic io, input logic [1:0] kind,
                      input logic [3:0] bits);
    @(posedge ref_clk);
    msg_valid <= 1'b1;
    msg_is_io <= io;
    msg_kind  <= kind;
    out_bits  <= bits;
    @(posedge ref_clk);
    msg_valid <= 1'b0;
    msg_is_io <= ~io;
    msg_kind  <= ~kind;
    out_bits  <= ~bits;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // take the assembly late, so either update order in the slave is covered
  always @(posedge ref_clk)
  begin
    seen_q <= {seen_q[0], tx_req};
    if (seen_q[1])
    begin
      rx_asm <= in_bits;
    end
  end

  // raw sensor bits decoded by master logic, bit0 = first sensor
  always_comb
  begin
    case ({rx_asm[0], rx_asm[1], rx_asm[2], rx_asm[3]})
      4'ha:    rx_dec = 4'h1;
      4'h1:    rx_dec = 4'h2;
      4'h6:    rx_dec = 4'h4;
      4'h8:    rx_dec = 4'h8;
      default: rx_dec = 4'h0;
    endcase
  end
endmodule // vsf_master_model

// file: dv/tb_valve_state_fieldbus_slave.sv
// self-checking testbench of the valve state fieldbus slave
`timescale 1ns/10ps
module tb_valve_state_fieldbus_slave;
  logic        ref_clk, rst, can_bus_off, reg_wr, reg_rd;
  logic [3:0]  sens;      // first sensor in bit 3
  logic [5:0]  addr_sw;
  logic [1:0]  baud_sw;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic        m_valid, m_io, tx_req, main_p, upper_p, lower_p, bus_lost;
  logic [1:0]  m_kind, baud_sel;
  logic [3:0]  m_bits, st;
  logic [2:0]  pilot_boost, pil;
  logic [5:0]  node_address;
  int          errors, n_tests, n;
  // per type, patterns of closed, open, upper lift, lower lift
  logic [3:0]  pat_tbl [4][4] = '{'{4'ha, 4'h1, 4'h0, 4'h0},
    '{4'h8, 4'h1, 4'h4, 4'ha}, '{4'ha, 4'h1, 4'h6, 4'h8}, '{4'h0, 4'h0,
    4'h0, 4'h0}};
  logic [5:0]  addr_tbl [4] = '{6'h01, 6'h20, 6'h2a, 6'h15};
  logic [1:0]  baud_tbl [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  assign pil = {lower_p, upper_p, main_p};

  vsf_top #(.PULL_CYC(5), .WDOG_CYC(50)) dut (
    .ref_clk(ref_clk), .rst(rst), .ext_sensor_target_a(sens[3]),
    .ext_sensor_target_b(sens[2]), .int_sensor_target_a(sens[1]),
    .int_sensor_target_b(sens[0]), .addr_sw(addr_sw), .baud_sw(baud_sw),
    .msg_valid(m_valid), .msg_is_io(m_io), .msg_kind(m_kind),
    .pilot_out_bit0(m_bits[0]), .pilot_out_bit1(m_bits[1]),
    .pilot_out_bit2(m_bits[2]), .pilot_out_bit3(m_bits[3]),
    .can_bus_off(can_bus_off), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_req(tx_req), .state_in_bit0(st[0]), .state_in_bit1(st[1]),
    .state_in_bit2(st[2]), .state_in_bit3(st[3]), .main_stroke_pilot(main_p),
    .upper_lift_pilot(upper_p), .lower_lift_pilot(lower_p),
    .pilot_boost(pilot_boost), .bus_lost(bus_lost),
    .node_address(node_address), .baud_sel(baud_sel));

  vsf_master_model mdl (.ref_clk(ref_clk), .msg_valid(m_valid),
    .msg_is_io(m_io), .msg_kind(m_kind), .out_bits(m_bits),
    .tx_req(tx_req), .in_bits(st));

  //////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // value compare, unknowns never match
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // register write, strobe held for one sampled edge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // register read, data taken in the cycle after the strobe only
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_ctrl(input logic [1:0] vt, input logic [2:0] safe,
                          input logic cos);
    reg_write(8'h00, {23'h0, cos, 1'b0, safe, 2'h0, vt});
  endtask

  // reset for ten cycles; outputs checked while it is held
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("node_address_rst", 32'h3f, node_address);
    chk("baud_sel_rst", 32'h0, baud_sel);
    chk("bus_lost_rst", 32'h1, bus_lost);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // poll, then the answer one cycle and the pilots two cycles later
  task automatic poll(input logic [1:0] kind, input logic [3:0] bits);
    mdl.send(1'b1, kind, bits);
    #1;
    chk("tx_req", 32'h1, tx_req);
    @(posedge ref_clk);
    #1;
  endtask

  // expected input assembly; unknown patterns leave it empty
  function automatic logic [3:0] exp_st(input logic [1:0] vt,
                                        input logic [3:0] p);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 4; k++)
      if (p == pat_tbl[vt][k] && (vt != 2'h0 || k < 2))
        r[k] = 1'b1;
    if (vt == 2'h3)
      r = {p[0], p[1], p[2], p[3]};
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    sens = 4'h0;
    addr_sw = 6'h3f;
    baud_sw = 2'h0;
    can_bus_off = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    n_tests = 0;
    // switches sampled once, later moves ignored
    for (int i = 0; i < 4; i++)
    begin
      addr_sw <= addr_tbl[i];
      baud_sw <= 2'(i);
      do_reset();
      addr_sw <= ~addr_tbl[i];
      baud_sw <= ~2'(i);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("node_address", 32'(addr_tbl[i]), node_address);
      chk("baud_sel", 32'(baud_tbl[i]), baud_sel);
      reg_read(8'h08, rd);
      chk("config", {22'h0, baud_tbl[i], 2'h0, addr_tbl[i]}, rd);
    end
    reg_read(8'h00, rd);
    chk("ctrl_rst", 32'h2, rd);
    // every pattern under every valve type
    for (int vt = 0; vt < 4; vt++)
    begin
      set_ctrl(2'(vt), 3'h0, 1'b0);
      for (int p = 0; p < 16; p++)
      begin
        sens <= 4'(p);
        repeat (2) @(posedge ref_clk);
        poll(2'h0, 4'h0);
        chk("state", 32'(exp_st(2'(vt), 4'(p))), st);
        // the master takes the assembly two edges after the answer
        repeat (2) @(posedge ref_clk);
        #1;
        chk("rx_asm", 32'(exp_st(2'(vt), 4'(p))), mdl.rx_asm);
        if (vt == 3)
          chk("rx_dec", 32'(exp_st(2'h2, 4'(p))), mdl.rx_dec);
      end
    end
    // pilot mapping, bit 3 ignored
    for (int b = 0; b < 16; b++)
    begin
      poll(2'h0, 4'(b));
      chk("pilots", 32'(b[2:0]), pil);
    end
    // full power for exactly PULL_CYC cycles after switch-on
    poll(2'h0, 4'h8);
    poll(2'h0, 4'h9);
    n = 0;
    while (pilot_boost[0] === 1'b1 && n < 20)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("boost_cycles", 32'd5, n);
    chk("holding", 32'h1, pil);
    // bus off gives default safe state, then the programmed one
    can_bus_off <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("bus_lost_off", 32'h1, bus_lost);
    chk("pilots_safe0", 32'h0, pil);
    can_bus_off <= 1'b0;
    set_ctrl(2'h2, 3'h5, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("pilots_safe5", 32'h5, pil);
    poll(2'h0, 4'h2);
    chk("pilots_back", 32'h2, pil);
    repeat (60) @(posedge ref_clk);
    #1;
    chk("bus_lost_quiet", 32'h1, bus_lost);
    chk("pilots_quiet", 32'h5, pil);
    // management messages only counted; strobe leaves pilots alone
    do_reset();
    poll(2'h0, 4'h1);
    mdl.send(1'b0, 2'h0, 4'h6);
    #1;
    chk("tx_mgmt", 32'h0, tx_req);
    @(posedge ref_clk);
    #1;
    chk("pilots_mgmt", 32'h1, pil);
    poll(2'h1, 4'h6);
    chk("pilots_strobe", 32'h1, pil);
    // change-of-state message from the master carries pilot data only
    mdl.send(1'b1, 2'h2, 4'h4);
    #1;
    chk("tx_cos_msg", 32'h0, tx_req);
    @(posedge ref_clk);
    #1;
    chk("pilots_cos_msg", 32'h4, pil);
    reg_read(8'h0c, rd);
    chk("msgcnt", 32'h0001_0003, rd);
    reg_write(8'h10, 32'hffff_ffff);
    reg_read(8'h10, rd);
    chk("unmapped", 32'h0, rd);
    // change of state sends without a poll
    set_ctrl(2'h2, 3'h0, 1'b1);
    sens <= 4'h6;
    n = 0;
    while (tx_req !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("cos_tx", 32'h1, tx_req);
    @(posedge ref_clk);
    #1;
    chk("cos_state", 32'h4, st);
    // status: bus alive, lower lift pilot on, upper seat lift decoded
    reg_read(8'h04, rd);
    chk("status", 32'h44, rd);
    end_sim();
  end
endmodule // tb_valve_state_fieldbus_slave
